// >>> logic/accel_csr_consts.vh
// Purpose: Constants for the acceleration control and status registers
// Assumes: AHB-Lite word bus, byte address = 4 * register index
// Notes:   Register indices, write masks and field positions
`ifndef ACCEL_CSR_CONSTS_VH
`define ACCEL_CSR_CONSTS_VH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define IDX_FILTER_CTRL   8'h21
`define IDX_PIN1_ROUTE    8'h22
`define IDX_FORMAT_CTRL   8'h23
`define IDX_REBOOT_CTRL   8'h24
`define IDX_SECOND_PAD_ROUTE    8'h25
`define IDX_REFERENCE     8'h26
`define IDX_AXIS_STATUS   8'h27
`define IDX_X_LOW         8'h28
`define IDX_X_HIGH        8'h29

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define CSR_RESET         8'h00
`define FORMAT_MASK       8'hF9
`define REBOOT_MASK       8'hCF
`define SECOND_PAD_MASK         8'hFA

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FMODE_HI          7
`define FMODE_LO          6
`define FCUT_HI           5
`define FCUT_LO           4
`define FOUT_BIT          3
`define FTAP_BIT          2
`define FEV2_BIT          1
`define FEV1_BIT          0
`define BLOCK_BIT         7
`define ORDER_BIT         6
`define RANGE_HI          5
`define RANGE_LO          4
`define HRES_BIT          3
`define WIRE_BIT          0
`define BOOT_BIT          7
`define QUEUE_BIT         6
`define LATCH1_BIT        3
`define FOURD1_BIT        2
`define LATCH2_BIT        1
`define FOURD2_BIT        0
`define POL_BIT           1
`define PIN1_TAP_BIT      7
`define PIN1_EV1_BIT      6
`define PIN1_EV2_BIT      5
`define PIN1_RDY1_BIT     4
`define PIN1_RDY2_BIT     3
`define PIN1_WMARK_BIT    2
`define PIN1_QOVR_BIT     1
`define SECOND_PAD_EN_HI        7
`define SECOND_PAD_EN_LO        3

// ----------------------------------------
// Mode codes and bus
// ----------------------------------------
`define MODE_RESET_READ   2'h0
`define MODE_AUTO_RESET   2'h3
`define RATE_OFF          4'h0
`define HTRANS_NONSEQ     2'h2
`define RDATA_ZERO        32'h00000000

`endif

// >>> logic/axis_flag_pair.v
// Purpose: Ready and overrun flag pair for one axis or full set
// Assumes: Strobes are single-cycle, same clock
// Notes:   Set beats clear for ready in the same cycle; clear beats set for overrun
`default_nettype none
module axis_flag_pair (
	input  wire clk,
	input  wire rstn,
	input  wire sample,
	input  wire clear,
	output reg  ready,
	output reg  overrun
);
	// ----------------------------------------
	// Flags
	// ----------------------------------------
	always @(posedge clk) begin
		if (!rstn) begin
			ready <= 1'b0;
			overrun <= 1'b0;
		end else begin
			ready <= sample | (ready & ~clear);
			// Read in the same cycle counts as consumed
			overrun <= (sample & ready & ~clear) |
				(overrun & ~clear);
		end
	end
endmodule // axis_flag_pair
`default_nettype wire

// >>> logic/ahb_reg_port.v
// Purpose: AHB-Lite slave front end producing register strobes
// Assumes: Single word transfers, one slave
// Notes:   One wait state when a read follows a write
`default_nettype none
`include "accel_csr_consts.vh"
module ahb_reg_port (
	input  wire        clk,
	input  wire        rstn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire        hready,
	input  wire [31:0] hwdata,
	output wire        hreadyout,
	output wire        rd_en,
	output wire [7:0]  rd_idx,
	output wire        wr_en,
	output reg  [7:0]  wr_idx,
	output wire [7:0]  wr_data
);
	reg        wr_pend;
	wire       req;
	wire       stall;

	// ----------------------------------------
	// Address phase
	// ----------------------------------------
	assign req = hsel & htrans[1] & hready;
	// Stall keeps a read from seeing a register mid-write
	assign stall = wr_pend & hsel & htrans[1] & ~hwrite;
	assign hreadyout = ~stall;
	assign rd_en = req & ~hwrite & ~stall;
	assign rd_idx = haddr[9:2];
	assign wr_en = wr_pend;
	assign wr_data = hwdata[7:0];

	// ----------------------------------------
	// Data phase capture
	// ----------------------------------------
	always @(posedge clk) begin
		if (!rstn) begin
			wr_pend <= 1'b0;
			wr_idx <= 8'h00;
		end else begin
			wr_pend <= req & hwrite & ~stall;
			if (req & hwrite)
				wr_idx <= haddr[9:2];
		end
	end
endmodule // ahb_reg_port
`default_nettype wire

// >>> logic/accel_control_status_regs.v
// Purpose: Control/status register set of a three-axis accel channel
// Assumes: Sensor core signals share CLK; registers on AHB-Lite
// Notes:   Unmapped reads return zero, writes ignored, always OKAY
//
// The implementer's own choice: the AHB-Lite slave port.
`default_nettype none
`include "accel_csr_consts.vh"
module accel_control_status_regs (
	input  wire        CLK,
	input  wire        RSTN,
	input  wire        HSEL,
	input  wire [31:0] HADDR,
	input  wire [1:0]  HTRANS,
	input  wire        HWRITE,
	input  wire [2:0]  HSIZE,
	input  wire        HREADY,
	input  wire [31:0] HWDATA,
	output reg  [31:0] HRDATA,
	output wire        HREADYOUT,
	output wire        HRESP,
	input  wire [3:0]  RATE_SEL,
	input  wire [15:0] X_RAW,
	input  wire [15:0] X_FILT,
	input  wire        SAMPLE_X,
	input  wire        SAMPLE_Y,
	input  wire        SAMPLE_Z,
	input  wire        SET_DONE,
	input  wire        Y_READ,
	input  wire        Z_READ,
	input  wire        TAP_EVT,
	input  wire        EVENT1_EVT,
	input  wire        EVENT2_EVT,
	input  wire        READY1_EVT,
	input  wire        READY2_EVT,
	input  wire        WATERMARK_EVT,
	input  wire        QUEUE_OVR_EVT,
	input  wire        ACTIVE_EVT,
	input  wire        SIX_DIR1,
	input  wire        SIX_DIR2,
	input  wire        RELOAD_DONE,
	output reg         FIRST_IRQ_PIN,
	output reg         SECOND_PAD,
	output wire [1:0]  FILTER_MODE,
	output wire [1:0]  FILTER_CUTOFF,
	output reg         FILTER_RESET,
	output wire        TAP_FILTER_EN,
	output wire        EVENT1_FILTER_EN,
	output wire        EVENT2_FILTER_EN,
	output reg  [15:0] QUEUE_X,
	output wire [7:0]  REFERENCE,
	output wire [1:0]  RANGE_SEL,
	output wire        HIGH_RESOLUTION,
	output wire        WIRE3_MODE,
	output wire        QUEUE_EN,
	output wire        RELOAD_REQ,
	output wire        LATCH_EVENT1,
	output wire        LATCH_EVENT2,
	output wire        FOUR_DIR1,
	output wire        FOUR_DIR2,
	output wire        POWER_DOWN
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	wire        rd_en;
	wire [7:0]  rd_idx;
	wire        wr_en;
	wire [7:0]  wr_idx;
	wire [7:0]  wr_data;
	reg  [7:0]  filter_ctrl;
	reg  [7:0]  pin1_route;
	reg  [7:0]  format_ctrl;
	reg  [7:0]  reboot_ctrl;
	reg  [7:0]  second_pad_route;
	reg  [7:0]  reference_value;
	reg  [15:0] x_word;
	reg         pair_pend;
	reg         pend_low;
	reg  [7:0]  rd_mux;
	wire        rd_low;
	wire        rd_high;
	wire        x_done;
	wire        hold_x;
	wire [3:0]  flag_sample;
	wire [3:0]  flag_clear;
	wire [3:0]  flag_ready;
	wire [3:0]  flag_ovr;
	wire [7:0]  axis_status;
	wire [6:0]  pin1_events;
	wire [4:0]  second_pad_events;
	wire        irq_polarity;
	wire        block_update;
	wire        byte_order_sel;
	wire [1:0]  filter_mode_sel;
	wire        filter_reset_on_read;
	wire        auto_reset;
	wire        tap_to_pin1;
	wire        event1_to_pin1;
	wire        event2_to_pin1;
	wire        ready1_to_pin1;
	wire        ready2_to_pin1;
	wire        watermark_to_pin1;
	wire        queue_overrun_to_pin1;
	wire        pin1_active;
	wire        second_pad_active;
	wire        x_ready;
	wire        y_ready;
	wire        z_ready;
	wire        all_axes_ready;
	wire        x_overrun;
	wire        y_overrun;
	wire        z_overrun;
	wire        all_axes_overrun;

	// ----------------------------------------
	// Bus front end
	// ----------------------------------------
	ahb_reg_port u_port (
		.clk       (CLK),
		.rstn      (RSTN),
		.hsel      (HSEL),
		.haddr     (HADDR),
		.htrans    (HTRANS),
		.hwrite    (HWRITE),
		.hready    (HREADY),
		.hwdata    (HWDATA),
		.hreadyout (HREADYOUT),
		.rd_en     (rd_en),
		.rd_idx    (rd_idx),
		.wr_en     (wr_en),
		.wr_idx    (wr_idx),
		.wr_data   (wr_data)
	);
	assign HRESP = 1'b0;

	// ----------------------------------------
	// Field decode
	// ----------------------------------------
	assign filter_mode_sel = filter_ctrl[`FMODE_HI:`FMODE_LO];
	assign FILTER_MODE = filter_mode_sel;
	// Corner relative to rate is resolved inside the filter core
	assign FILTER_CUTOFF = filter_ctrl[`FCUT_HI:`FCUT_LO];
	assign TAP_FILTER_EN = filter_ctrl[`FTAP_BIT];
	assign EVENT1_FILTER_EN = filter_ctrl[`FEV1_BIT];
	assign EVENT2_FILTER_EN = filter_ctrl[`FEV2_BIT];
	assign block_update = format_ctrl[`BLOCK_BIT];
	assign byte_order_sel = format_ctrl[`ORDER_BIT];
	assign RANGE_SEL = format_ctrl[`RANGE_HI:`RANGE_LO];
	assign HIGH_RESOLUTION = format_ctrl[`HRES_BIT];
	assign WIRE3_MODE = format_ctrl[`WIRE_BIT];
	assign RELOAD_REQ = reboot_ctrl[`BOOT_BIT];
	assign QUEUE_EN = reboot_ctrl[`QUEUE_BIT];
	assign LATCH_EVENT1 = reboot_ctrl[`LATCH1_BIT];
	assign LATCH_EVENT2 = reboot_ctrl[`LATCH2_BIT];
	// Four-direction is meaningless without six-direction
	assign FOUR_DIR1 = reboot_ctrl[`FOURD1_BIT] & SIX_DIR1;
	assign FOUR_DIR2 = reboot_ctrl[`FOURD2_BIT] & SIX_DIR2;
	assign irq_polarity = second_pad_route[`POL_BIT];
	assign REFERENCE = reference_value;
	assign POWER_DOWN = (RATE_SEL == `RATE_OFF);

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always @(posedge CLK) begin
		if (!RSTN) begin
			filter_ctrl <= `CSR_RESET;
			pin1_route <= `CSR_RESET;
			format_ctrl <= `CSR_RESET;
			reboot_ctrl <= `CSR_RESET;
			second_pad_route <= `CSR_RESET;
			reference_value <= `CSR_RESET;
		end else begin
			if (wr_en && wr_idx == `IDX_FILTER_CTRL)
				filter_ctrl <= wr_data;
			if (wr_en && wr_idx == `IDX_PIN1_ROUTE)
				pin1_route <= wr_data;
			// Unused positions stored as zero whatever host sends
			if (wr_en && wr_idx == `IDX_FORMAT_CTRL)
				format_ctrl <= wr_data & `FORMAT_MASK;
			if (wr_en && wr_idx == `IDX_REBOOT_CTRL)
				reboot_ctrl <= wr_data & `REBOOT_MASK;
			else if (RELOAD_DONE)
				reboot_ctrl[`BOOT_BIT] <= 1'b0;
			if (wr_en && wr_idx == `IDX_SECOND_PAD_ROUTE)
				second_pad_route <= wr_data & `SECOND_PAD_MASK;
			if (wr_en && wr_idx == `IDX_REFERENCE)
				reference_value <= wr_data;
		end
	end

	// ----------------------------------------
	// Output word pairing
	// ----------------------------------------
	assign rd_low = rd_en && rd_idx == `IDX_X_LOW;
	assign rd_high = rd_en && rd_idx == `IDX_X_HIGH;
	assign x_done = pair_pend &
		((rd_low & ~pend_low) | (rd_high & pend_low));
	// Hold only between the two byte reads of one word
	assign hold_x = block_update & pair_pend & ~x_done;

	always @(posedge CLK) begin
		if (!RSTN) begin
			pair_pend <= 1'b0;
			pend_low <= 1'b0;
		end else if (x_done) begin
			pair_pend <= 1'b0;
		end else if (!pair_pend && (rd_low || rd_high)) begin
			pair_pend <= 1'b1;
			pend_low <= rd_low;
		end
	end

	always @(posedge CLK) begin
		if (!RSTN) begin
			x_word <= 16'h0000;
			QUEUE_X <= 16'h0000;
		end else if (SAMPLE_X && !POWER_DOWN) begin
			if (!hold_x) begin
				if (filter_ctrl[`FOUT_BIT])
					x_word <= X_FILT;
				else
					x_word <= X_RAW;
			end
			if (filter_ctrl[`FOUT_BIT])
				QUEUE_X <= X_FILT;
			else
				QUEUE_X <= X_RAW;
		end
	end

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	assign flag_sample = {SET_DONE, SAMPLE_Z, SAMPLE_Y, SAMPLE_X} &
		{4{~POWER_DOWN}};
	assign flag_clear = {x_done | Y_READ | Z_READ, Z_READ, Y_READ,
		x_done};

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_flag
			axis_flag_pair u_flag (
				.clk     (CLK),
				.rstn    (RSTN),
				.sample  (flag_sample[g]),
				.clear   (flag_clear[g]),
				.ready   (flag_ready[g]),
				.overrun (flag_ovr[g])
			);
		end
	endgenerate

	assign x_ready = flag_ready[0];
	assign y_ready = flag_ready[1];
	assign z_ready = flag_ready[2];
	assign all_axes_ready = flag_ready[3];
	assign x_overrun = flag_ovr[0];
	assign y_overrun = flag_ovr[1];
	assign z_overrun = flag_ovr[2];
	assign all_axes_overrun = flag_ovr[3];
	assign axis_status = {all_axes_overrun, z_overrun, y_overrun,
		x_overrun, all_axes_ready, z_ready, y_ready,
		x_ready};

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always @* begin
		case (rd_idx)
		`IDX_FILTER_CTRL: rd_mux = filter_ctrl;
		`IDX_PIN1_ROUTE: rd_mux = pin1_route;
		`IDX_FORMAT_CTRL: rd_mux = format_ctrl;
		`IDX_REBOOT_CTRL: rd_mux = reboot_ctrl;
		`IDX_SECOND_PAD_ROUTE: rd_mux = second_pad_route;
		`IDX_REFERENCE: rd_mux = reference_value;
		`IDX_AXIS_STATUS: rd_mux = axis_status;
		`IDX_X_LOW: begin
			if (byte_order_sel)
				rd_mux = x_word[15:8];
			else
				rd_mux = x_word[7:0];
		end
		`IDX_X_HIGH: begin
			if (byte_order_sel)
				rd_mux = x_word[7:0];
			else
				rd_mux = x_word[15:8];
		end
		default: rd_mux = 8'h00;
		endcase
	end

	always @(posedge CLK) begin
		if (!RSTN)
			HRDATA <= `RDATA_ZERO;
		else if (rd_en)
			HRDATA <= {24'h000000, rd_mux};
	end

	// ----------------------------------------
	// Filter reset requests
	// ----------------------------------------
	assign filter_reset_on_read = (filter_mode_sel == `MODE_RESET_READ) &
		rd_en & (rd_idx == `IDX_REFERENCE);
	assign auto_reset = (filter_mode_sel == `MODE_AUTO_RESET) &
		(EVENT1_EVT | EVENT2_EVT);

	always @(posedge CLK) begin
		if (!RSTN)
			FILTER_RESET <= 1'b0;
		else
			FILTER_RESET <= filter_reset_on_read | auto_reset;
	end

	// ----------------------------------------
	// Interrupt pins
	// ----------------------------------------
	// Event generators clear their own lines on source reads
	assign pin1_events = {TAP_EVT, EVENT1_EVT, EVENT2_EVT, READY1_EVT,
		READY2_EVT, WATERMARK_EVT, QUEUE_OVR_EVT};
	assign second_pad_events = {TAP_EVT, EVENT1_EVT, EVENT2_EVT,
		reboot_ctrl[`BOOT_BIT], ACTIVE_EVT};
	assign tap_to_pin1 = pin1_route[`PIN1_TAP_BIT];
	assign event1_to_pin1 = pin1_route[`PIN1_EV1_BIT];
	assign event2_to_pin1 = pin1_route[`PIN1_EV2_BIT];
	assign ready1_to_pin1 = pin1_route[`PIN1_RDY1_BIT];
	assign ready2_to_pin1 = pin1_route[`PIN1_RDY2_BIT];
	assign watermark_to_pin1 = pin1_route[`PIN1_WMARK_BIT];
	assign queue_overrun_to_pin1 = pin1_route[`PIN1_QOVR_BIT];
	assign pin1_active = |(pin1_events & {tap_to_pin1, event1_to_pin1,
		event2_to_pin1, ready1_to_pin1, ready2_to_pin1, watermark_to_pin1,
		queue_overrun_to_pin1});
	assign second_pad_active = |(second_pad_events &
		second_pad_route[`SECOND_PAD_EN_HI:`SECOND_PAD_EN_LO]);

	always @(posedge CLK) begin
		if (!RSTN) begin
			FIRST_IRQ_PIN <= 1'b0;
			SECOND_PAD <= 1'b0;
		end else begin
			FIRST_IRQ_PIN <= pin1_active ^ irq_polarity;
			SECOND_PAD <= second_pad_active ^ irq_polarity;
		end
	end
endmodule // accel_control_status_regs
`default_nettype wire

// >>> testbench/accel_csr_checker.sv
// Purpose: Port assertions for the accel register block
// Assumes: One clock; a write lands when its data phase ends
// Notes:   Helper logic follows the write data phase
`default_nettype none
module accel_csr_checker (
	input wire logic        CLK,
	input wire logic        RSTN,
	input wire logic        HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0]  HTRANS,
	input wire logic        HWRITE,
	input wire logic        HREADY,
	input wire logic [31:0] HWDATA,
	input wire logic        HREADYOUT,
	input wire logic [3:0]  RATE_SEL,
	input wire logic        SAMPLE_X,
	input wire logic        EVENT1_EVT,
	input wire logic        EVENT2_EVT,
	input wire logic        SIX_DIR1,
	input wire logic        SIX_DIR2,
	input wire logic        RELOAD_DONE,
	input wire logic [1:0]  FILTER_MODE,
	input wire logic        FILTER_RESET,
	input wire logic [15:0] QUEUE_X,
	input wire logic [7:0]  REFERENCE,
	input wire logic [1:0]  RANGE_SEL,
	input wire logic        HIGH_RESOLUTION,
	input wire logic        WIRE3_MODE,
	input wire logic        QUEUE_EN,
	input wire logic        RELOAD_REQ,
	input wire logic        FOUR_DIR1,
	input wire logic        FOUR_DIR2,
	input wire logic        POWER_DOWN
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       take;
	logic       wr_dp;
	logic       wr_end;
	logic [7:0] wr_ix;
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RSTN);
	assign take = HSEL && HTRANS[1] && HREADY && HREADYOUT;
	assign wr_end = wr_dp && HREADYOUT;
	// Data phase may stretch by a wait state
	always_ff @(posedge CLK) begin
		if (!RSTN)
			wr_dp <= 1'b0;
		else if (HREADYOUT)
			wr_dp <= take && HWRITE;
		if (take)
			wr_ix <= HADDR[9:2];
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_filt_read;
		take && !HWRITE && HADDR[9:2] == 8'h26 && FILTER_MODE == 2'h0
			|=> FILTER_RESET;
	endproperty
	a_filt_read: assert property (p_filt_read)
		else $error("no filter reset on reference read");
	property p_filt_auto;
		FILTER_MODE == 2'h3 && (EVENT1_EVT || EVENT2_EVT) |=> FILTER_RESET;
	endproperty
	a_filt_auto: assert property (p_filt_auto)
		else $error("no filter reset on event");
	property p_filt_quiet;
		FILTER_RESET |-> $past(FILTER_MODE) != 2'h1
			&& $past(FILTER_MODE) != 2'h2;
	endproperty
	a_filt_quiet: assert property (p_filt_quiet)
		else $error("filter reset in a normal mode");
	property p_queue_hold;
		!SAMPLE_X || POWER_DOWN |=> $stable(QUEUE_X);
	endproperty
	a_queue_hold: assert property (p_queue_hold)
		else $error("queue word moved without sample");
	property p_pd;
		POWER_DOWN == (RATE_SEL == 4'h0);
	endproperty
	a_pd: assert property (p_pd)
		else $error("power-down flag wrong");
	property p_four;
		(!FOUR_DIR1 || SIX_DIR1) && (!FOUR_DIR2 || SIX_DIR2);
	endproperty
	a_four: assert property (p_four)
		else $error("four-direction without six-direction");
	property p_boot_wr;
		wr_end && wr_ix == 8'h24 |=> RELOAD_REQ == $past(HWDATA[7])
			&& QUEUE_EN == $past(HWDATA[6]);
	endproperty
	a_boot_wr: assert property (p_boot_wr)
		else $error("reboot or queue bit not written");
	property p_boot_done;
		RELOAD_DONE && !wr_dp |=> !RELOAD_REQ;
	endproperty
	a_boot_done: assert property (p_boot_done)
		else $error("reboot request stayed after reload");
	property p_format;
		wr_end && wr_ix == 8'h23 |=> {RANGE_SEL, HIGH_RESOLUTION, WIRE3_MODE}
			== {$past(HWDATA[5:3]), $past(HWDATA[0])};
	endproperty
	a_format: assert property (p_format)
		else $error("format fields not written");
	property p_ref;
		wr_end && wr_ix == 8'h26 |=> REFERENCE == $past(HWDATA[7:0]);
	endproperty
	a_ref: assert property (p_ref)
		else $error("reference not written");
endmodule // accel_csr_checker
bind accel_control_status_regs accel_csr_checker chk (.CLK(CLK),
	.RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
	.HWRITE(HWRITE), .HREADY(HREADY), .HWDATA(HWDATA),
	.HREADYOUT(HREADYOUT), .RATE_SEL(RATE_SEL), .SAMPLE_X(SAMPLE_X),
	.EVENT1_EVT(EVENT1_EVT), .EVENT2_EVT(EVENT2_EVT), .SIX_DIR1(SIX_DIR1),
	.SIX_DIR2(SIX_DIR2), .RELOAD_DONE(RELOAD_DONE),
	.FILTER_MODE(FILTER_MODE), .FILTER_RESET(FILTER_RESET),
	.QUEUE_X(QUEUE_X), .REFERENCE(REFERENCE), .RANGE_SEL(RANGE_SEL),
	.HIGH_RESOLUTION(HIGH_RESOLUTION), .WIRE3_MODE(WIRE3_MODE),
	.QUEUE_EN(QUEUE_EN), .RELOAD_REQ(RELOAD_REQ), .FOUR_DIR1(FOUR_DIR1),
	.FOUR_DIR2(FOUR_DIR2), .POWER_DOWN(POWER_DOWN));
`default_nettype wire

// >>> testbench/ahb_host.sv
// Purpose: Host model, single word AHB-Lite transfers
// Assumes: Caller enters just after a rising edge
// Notes:   Released address and write lines show inverted values; HTRANS returns to idle
`default_nettype none
module ahb_host (
	input  wire logic        CLK,
	input  wire logic        HREADY,
	input  wire logic [31:0] HRDATA,
	output var  logic        HSEL,
	output var  logic [31:0] HADDR,
	output var  logic [1:0]  HTRANS,
	output var  logic        HWRITE,
	output var  logic [2:0]  HSIZE,
	output var  logic [31:0] HWDATA
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		HSEL = 1'b0;
		HADDR = 32'h0;
		HTRANS = 2'h0;
		HWRITE = 1'b0;
		HSIZE = 3'h2;
		HWDATA = 32'h0;
	end
	task automatic xfer(input logic w, input logic [7:0] idx,
		input logic [31:0] wd, output logic [31:0] rd);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HADDR <= {22'h0, idx, 2'h0};
		HWRITE <= w;
		HSIZE <= 3'h2;
		do @(posedge CLK); while (HREADY !== 1'b1);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HADDR <= ~HADDR;
		HWRITE <= ~w;
		HWDATA <= w ? wd : ~wd;
		do @(posedge CLK); while (HREADY !== 1'b1);
		rd = HRDATA;
	endtask
endmodule // ahb_host
`default_nettype wire

// >>> testbench/accel_control_status_regs_bench.sv
// Purpose: Self-checking bench for the accel register block
// Assumes: Host model on the bus; sensor side driven here
// Notes:   Model keeps registers, status flags and X word
`default_nettype none
module accel_control_status_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0, rstn = 1'b0, rdone = 1'b0;
	logic        hsel, hwrite, hreadyout, hresp, irq1, second_pad, frst;
	logic        tapf, e1f, e2f, hres, wire3, qen, rreq, lat1, lat2;
	logic        fd1, fd2, pd;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans, fmode, fcut, range, yz = 2'h0, six = 2'h0;
	logic [2:0]  hsize;
	logic [3:0]  rate = 4'h1, smp = 4'h0;
	logic [15:0] xraw = 16'h0, xfilt = 16'h0, qx;
	logic [7:0]  ev = 8'h0, refv;
	int          error_cnt = 0, check_count = 0, seed = 32'h2018;
	int          st = 0, xw = 0, qm = 0, open = 0, sh [6];
	int          wm [6] = '{8'hFF, 8'hFE, 8'hF9, 8'hCF, 8'hFA, 8'hFF};
	int          rm [6] = '{8'hFF, 8'hFF, 8'hF9, 8'hCF, 8'hFA, 8'hFF};
	always #4 clk = ~clk;
	ahb_host host (.CLK(clk), .HREADY(hreadyout), .HRDATA(hrdata),
		.HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
		.HSIZE(hsize), .HWDATA(hwdata));
	accel_control_status_regs DUT (.CLK(clk), .RSTN(rstn), .HSEL(hsel),
		.HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
		.HREADY(hreadyout), .HWDATA(hwdata), .HRDATA(hrdata),
		.HREADYOUT(hreadyout), .HRESP(hresp), .RATE_SEL(rate),
		.X_RAW(xraw), .X_FILT(xfilt), .SAMPLE_X(smp[0]),
		.SAMPLE_Y(smp[1]), .SAMPLE_Z(smp[2]), .SET_DONE(smp[3]),
		.Y_READ(yz[0]), .Z_READ(yz[1]), .TAP_EVT(ev[7]),
		.EVENT1_EVT(ev[6]), .EVENT2_EVT(ev[5]), .READY1_EVT(ev[4]),
		.READY2_EVT(ev[3]), .WATERMARK_EVT(ev[2]),
		.QUEUE_OVR_EVT(ev[1]), .ACTIVE_EVT(ev[0]), .SIX_DIR1(six[0]),
		.SIX_DIR2(six[1]), .RELOAD_DONE(rdone), .FIRST_IRQ_PIN(irq1),
		.SECOND_PAD(second_pad), .FILTER_MODE(fmode), .FILTER_CUTOFF(fcut),
		.FILTER_RESET(frst), .TAP_FILTER_EN(tapf),
		.EVENT1_FILTER_EN(e1f), .EVENT2_FILTER_EN(e2f), .QUEUE_X(qx),
		.REFERENCE(refv), .RANGE_SEL(range), .HIGH_RESOLUTION(hres),
		.WIRE3_MODE(wire3), .QUEUE_EN(qen), .RELOAD_REQ(rreq),
		.LATCH_EVENT1(lat1), .LATCH_EVENT2(lat2), .FOUR_DIR1(fd1),
		.FOUR_DIR2(fd2), .POWER_DOWN(pd));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		logic [31:0] q;
		host.xfer(1'b1, i, d, q);
		if (i >= 8'h21 && i <= 8'h26)
			sh[i - 8'h21] = d & rm[i - 8'h21];
	endtask
	task automatic rd(input logic [7:0] i, input logic [31:0] e);
		logic [31:0] q;
		host.xfer(1'b0, i, 32'h0, q);
		check(q, e);
	endtask
	// Reading the second byte of a pair clears the X and all-axes flags
	task automatic rdx(input logic [7:0] i);
		logic [7:0] b;
		b = ((i == 8'h29) ^ sh[2][6]) ? xw[15:8] : xw[7:0];
		rd(i, {24'h0, b});
		open = !open;
		if (!open)
			st &= ~8'h99;
	endtask
	task automatic pulse(input logic [3:0] m);
		xraw <= 16'($random(seed));
		xfilt <= 16'($random(seed));
		smp <= m;
		@(posedge clk);
		smp <= 4'h0;
		if (rate != 4'h0) begin
			for (int a = 0; a < 4; a++)
				if (m[a])
					st |= (((st >> a) & 1) << (a + 4)) | (1 << a);
			if (m[0])
				qm = sh[0][3] ? xfilt : xraw;
			if (m[0] && !(sh[2][7] && open))
				xw = qm;
		end
	endtask
	task automatic clr(input logic [1:0] m);
		yz <= m;
		@(posedge clk);
		yz <= 2'h0;
		st &= ~((m[0] ? 8'h22 : 8'h00) | (m[1] ? 8'h44 : 8'h00) | 8'h88);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Hang guard, far beyond the expected run
	initial begin
		#100us;
		error_cnt++;
		conclude();
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		for (int k = 8'h21; k <= 8'h29; k++)
			rd(8'(k), 32'h0);
		check({hresp, irq1, second_pad}, 3'h0);
		$display("reset values done");
		repeat (12) begin
			for (int k = 0; k < 6; k++)
				wr(8'(8'h21 + k), $random(seed) & wm[k]);
			for (int k = 0; k < 6; k++)
				rd(8'(8'h21 + k), sh[k]);
			wr(8'h20, $random(seed));
			wr(8'h27, $random(seed));
			rd(8'h20, 32'h0);
			rd(8'h27, st);
			six <= 2'($random(seed));
			ev <= 8'($random(seed));
			repeat (2) @(posedge clk);
			check({fmode, fcut, tapf, e2f, e1f},
				{sh[0][7:4], sh[0][2:0]});
			check({range, hres, wire3}, {sh[2][5:3], sh[2][0]});
			check({rreq, qen, lat1, lat2, refv}, {sh[3][7:6], sh[3][3],
				sh[3][1], sh[5][7:0]});
			check({fd1, fd2}, {sh[3][2] & six[0], sh[3][0] & six[1]});
			check(irq1, |(ev[7:1] & sh[1][7:1]) ^ sh[4][1]);
			check(second_pad, |({ev[7:5], sh[3][7], ev[0]} & sh[4][7:3])
				^ sh[4][1]);
		end
		wr(8'h24, 8'hFF);
		rd(8'h24, 8'hCF);
		wr(8'h25, 8'hFF);
		rd(8'h25, 8'hFA);
		$display("register tests done");
		wr(8'h24, 8'h80);
		@(posedge clk);
		check(rreq, 1'b1);
		rdone <= 1'b1;
		@(posedge clk);
		rdone <= 1'b0;
		@(posedge clk);
		check(rreq, 1'b0);
		$display("reboot test done");
		wr(8'h21, 8'h08);
		wr(8'h23, 8'h00);
		pulse(4'h1);
		rd(8'h27, st);
		check(qx, qm);
		pulse(4'h1);
		rd(8'h27, st);
		rdx(8'h28);
		rdx(8'h29);
		rd(8'h27, st);
		wr(8'h21, 8'h00);
		pulse(4'hF);
		rd(8'h27, st);
		check(qx, qm);
		pulse(4'hF);
		rd(8'h27, st);
		clr(2'h1);
		rd(8'h27, st);
		clr(2'h2);
		rdx(8'h29);
		rdx(8'h28);
		rd(8'h27, st);
		wr(8'h23, 8'h40);
		pulse(4'h1);
		rdx(8'h28);
		rdx(8'h29);
		wr(8'h23, 8'h80);
		pulse(4'h1);
		rdx(8'h28);
		pulse(4'h1);
		rdx(8'h29);
		pulse(4'h1);
		rdx(8'h28);
		rdx(8'h29);
		rate <= 4'h0;
		@(posedge clk);
		pulse(4'h1);
		rd(8'h27, st);
		check({pd, qx}, {1'b1, qm[15:0]});
		$display("data tests done");
		conclude();
	end
endmodule // accel_control_status_regs_bench
`default_nettype wire
